// ---- design/wlb_unit.v ----
// Word logic and BCD step execution unit with AHB-Lite register slave.
//
// What this block does
// [RULE1] With the condition bit at 0 nothing is executed and no destination or flag changes.
// [RULE2] Every execute request with the condition at 1 made while idle runs again, once per scan.
// [RULE3] Word XOR writes the bitwise XOR of the two sources to the destination.
// [RULE4] Word XNOR writes the inverted XOR of the two sources to the destination.
// [RULE5] A zero stored result from XOR, XNOR, increment or decrement sets the zero flag.
// [RULE6] A four hex digit constant is accepted as a logic source operand.
// [RULE7] Indirect addressing goes only through data memory words 0 to 511.
// [RULE8] A logic instruction with an indirect pointer out of range raises error and is skipped.
// [RULE9] Increment adds one in BCD to the destination word and writes it back there.
// [RULE10] Decrement subtracts one in BCD from the destination word and writes it back there.
// [RULE11] A non BCD operand for increment or decrement raises error and is skipped.
// [RULE12] An indirect step with a non BCD or too large pointer raises error and is skipped.
// [RULE13] An indirect operand reads the pointer, then uses and writes the word it names.
// [RULE14] Set carry forces the carry flag to 1 and clear carry forces it to 0.
// [RULE15] Function codes 36 to 41 are XOR, XNOR, increment, decrement, set carry, clear carry.
// [RULE16] A word is valid BCD only when every nibble is 0 to 9.
// [RULE17] A nonzero executed result clears the zero flag.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "wlb_defs.vh"
module wlb_unit #(
   parameter CHANNELS = 64
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Flags
   output reg         zero_flag,
   output reg         error_flag,
   output reg         carry_flag
);
   // One-hot sequencer states.
   localparam ST_IDLE  = 4'b0001;
   localparam ST_FETCH = 4'b0010;
   localparam ST_EXEC  = 4'b0100;
   localparam ST_WRITE = 4'b1000;

   // Channel store holds relay words; data memory holds the 512 DM words.
   reg  [15:0] chan_mem [0:CHANNELS-1];
   reg  [15:0] dm_mem   [0:`WLB_DM_WORDS-1];

   // Operand descriptors: [17:16] source, [15:0] address or constant.
   reg  [17:0] opa_r;
   reg  [17:0] opb_r;
   reg  [17:0] dst_r;
   reg  [5:0]  fun_r;
   reg         cond_r;
   reg  [3:0]  state_r;
   // Fetched operands and the pending result write.
   reg  [15:0] va_r;
   reg  [15:0] vb_r;
   reg  [15:0] res_r;
   reg         bad_r;
   reg  [8:0]  dm_addr_r;
   reg  [1:0]  wr_src_r;
   reg  [15:0] wr_addr_r;

   // Address phase capture.
   reg         ap_wr_r;
   reg         ap_rd_r;
   reg  [11:0] ap_addr_r;

   wire        ap_valid;
   wire [15:0] a_raw;
   wire [15:0] b_raw;
   wire [15:0] d_raw;
   wire        pa_ok;
   wire        pb_ok;
   wire        pd_ok;
   wire [8:0]  pa_idx;
   wire [8:0]  pb_idx;
   wire [8:0]  pd_idx;
   wire [15:0] step_res;
   wire        step_valid;
   wire        is_step;
   wire        is_logic;

   // Decoded command, operand modes and software load strobes.
   wire        step_down;
   wire        a_ind;
   wire        b_ind;
   wire        d_ind;
   wire        start_req;
   wire        chan_wr;
   wire        dm_wr;
   wire [31:0] status_word;

   assign ap_valid = hsel && hready && htrans[1];
   assign is_logic = (fun_r == `WLB_FUN_XOR) || (fun_r == `WLB_FUN_XNOR);
   assign is_step  = (fun_r == `WLB_FUN_INC) || (fun_r == `WLB_FUN_DEC);
   assign step_down = (fun_r == `WLB_FUN_DEC);
   assign a_ind     = (opa_r[17:16] == `WLB_SRC_IND);
   assign b_ind     = (opb_r[17:16] == `WLB_SRC_IND);
   assign d_ind     = (dst_r[17:16] == `WLB_SRC_IND);

   // The condition bit comes in the same data word as GO, and cond_r only takes that word at this
   // edge, so the start test reads hwdata directly. A GO that arrives while busy is dropped.
   assign start_req = ap_wr_r && (ap_addr_r == `WLB_REG_CTRL) && hwdata[`WLB_CTRL_GO] &&
                      hwdata[`WLB_CTRL_COND]; // [RULE1]

   // A software load loses to a result write in the same cycle, so software polls busy first.
   assign chan_wr = ap_wr_r && (ap_addr_r == `WLB_REG_CHAN);
   assign dm_wr   = ap_wr_r && (ap_addr_r == `WLB_REG_DMDATA);

   assign status_word = {28'h0000000, carry_flag, error_flag, zero_flag, (state_r != ST_IDLE)};

   // Raw fetch of a direct operand or pointer word.
   function [15:0] fetch_raw;
      input [17:0] d;
      begin
         case (d[17:16])
            `WLB_SRC_CHAN:  fetch_raw = chan_mem[d[5:0]];
            `WLB_SRC_CONST: fetch_raw = d[15:0]; // [RULE6]
            default:        fetch_raw = dm_mem[d[8:0]];
         endcase
      end
   endfunction

   assign a_raw = fetch_raw(opa_r);
   assign b_raw = fetch_raw(opb_r);
   assign d_raw = fetch_raw(dst_r);

   // Each operand has its own pointer check, so all three resolve in the single fetch cycle.
   wlb_ptr_check u_pa (
      .ptr      (a_raw),
      .need_bcd (1'b1),
      .ok       (pa_ok),
      .index    (pa_idx)
   );
   wlb_ptr_check u_pb (
      .ptr      (b_raw),
      .need_bcd (1'b1),
      .ok       (pb_ok),
      .index    (pb_idx)
   );
   wlb_ptr_check u_pd (
      .ptr      (d_raw),
      .need_bcd (1'b1),
      .ok       (pd_ok),
      .index    (pd_idx)
   );

   // The step unit also checks its own operand for valid BCD.
   wlb_bcd_step u_step (
      .value  (va_r),
      .down   (step_down),
      .result (step_res),
      .valid  (step_valid)
   );

   // Execution sequencer: fetch resolves pointers, exec computes, write stores.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r    <= ST_IDLE;
         va_r       <= 16'h0000;
         vb_r       <= 16'h0000;
         res_r      <= 16'h0000;
         bad_r      <= 1'b0;
         zero_flag  <= 1'b0;
         error_flag <= 1'b0;
         carry_flag <= 1'b0;
         wr_src_r   <= 2'h0;
         wr_addr_r  <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               // Each accepted GO is one scan's execution; repeated scans simply send GO again.
               if (start_req) begin // [RULE1] [RULE2]
                  state_r <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               // Pointer word and the word it names are both read here, in this one cycle. [RULE13]
               bad_r     <= 1'b0;
               va_r      <= a_ind ? dm_mem[pa_idx] : a_raw;
               vb_r      <= b_ind ? dm_mem[pb_idx] : b_raw;
               wr_src_r  <= d_ind ? `WLB_SRC_DM : dst_r[17:16];
               wr_addr_r <= d_ind ? {7'h00, pd_idx} : dst_r[15:0];
               if (is_step) begin
                  // A step takes its operand from the destination word itself.
                  va_r <= d_ind ? dm_mem[pd_idx] : d_raw;
                  bad_r <= d_ind && !pd_ok; // [RULE12]
               end else if (is_logic) begin
                  bad_r <= (a_ind && !pa_ok) ||
                           (b_ind && !pb_ok) ||
                           (d_ind && !pd_ok); // [RULE8]
               end
               state_r <= ST_EXEC;
            end
            ST_EXEC: begin
               state_r <= ST_IDLE;
               case (fun_r) // [RULE15]
                  `WLB_FUN_XOR,
                  `WLB_FUN_XNOR,
                  `WLB_FUN_INC,
                  `WLB_FUN_DEC: begin
                     // A skipped instruction leaves the destination and the zero flag as they were.
                     if (bad_r || (is_step && !step_valid)) begin
                        error_flag <= 1'b1; // [RULE11]
                     end else begin
                        error_flag <= 1'b0;
                        if (fun_r == `WLB_FUN_XOR)
                           res_r <= va_r ^ vb_r; // [RULE3]
                        else if (fun_r == `WLB_FUN_XNOR)
                           res_r <= ~(va_r ^ vb_r); // [RULE4]
                        else
                           res_r <= step_res;
                        state_r <= ST_WRITE;
                     end
                  end
                  // Carry commands leave the zero and error flags alone.
                  `WLB_FUN_STC: carry_flag <= 1'b1; // [RULE14]
                  `WLB_FUN_CLC: carry_flag <= 1'b0; // [RULE14]
                  default: ;
               endcase
            end
            ST_WRITE: begin
               // A constant destination stores nothing, but the zero flag still follows the result.
               zero_flag <= (res_r == 16'h0000); // [RULE5] [RULE17]
               state_r   <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Memory writes: execution result, then software loads.
   always @(posedge hclk) begin
      if (state_r == ST_WRITE) begin
         if (wr_src_r == `WLB_SRC_CHAN)
            chan_mem[wr_addr_r[5:0]] <= res_r; // [RULE3] [RULE4]
         else if (wr_src_r != `WLB_SRC_CONST)
            dm_mem[wr_addr_r[8:0]] <= res_r; // [RULE9] [RULE10] [RULE13]
      end else if (chan_wr) begin
         // Channel index and data arrive in one word, so the index is taken from that word.
         chan_mem[hwdata[21:16]] <= hwdata[15:0];
      end else if (dm_wr) begin
         dm_mem[dm_addr_r] <= hwdata[15:0];
      end
   end

   // Bus slave: zero wait state, always OKAY; unmapped reads return zero.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_r    <= 1'b0;
         ap_rd_r    <= 1'b0;
         ap_addr_r  <= 12'h000;
         hrdata     <= 32'h00000000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         opa_r      <= 18'h00000;
         opb_r      <= 18'h00000;
         dst_r      <= 18'h00000;
         fun_r      <= 6'h00;
         cond_r     <= 1'b0;
         dm_addr_r  <= 9'h000;
      end else begin
         ap_wr_r   <= ap_valid && hwrite;
         ap_rd_r   <= ap_valid && !hwrite;
         ap_addr_r <= haddr;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         // Register loads happen in the data phase, when hwdata stands.
         if (ap_wr_r) begin
            case (ap_addr_r)
               `WLB_REG_CTRL: begin
                  cond_r <= hwdata[`WLB_CTRL_COND];
                  fun_r  <= hwdata[`WLB_CTRL_FUN_HI:`WLB_CTRL_FUN_LO];
               end
               `WLB_REG_OPA:    opa_r      <= hwdata[17:0];
               `WLB_REG_OPB:    opb_r      <= hwdata[17:0];
               `WLB_REG_DST:    dst_r      <= hwdata[17:0];
               `WLB_REG_DMADDR: dm_addr_r  <= hwdata[8:0];
               default: ;
            endcase
         end
         // Read data is registered at the address phase so it stands for the whole data phase.
         if (ap_valid && !hwrite) begin
            case (haddr)
               `WLB_REG_CTRL:   hrdata <= {24'h000000, fun_r, cond_r, 1'b0};
               `WLB_REG_OPA:    hrdata <= {14'h0000, opa_r};
               `WLB_REG_OPB:    hrdata <= {14'h0000, opb_r};
               `WLB_REG_DST:    hrdata <= {14'h0000, dst_r};
               `WLB_REG_STATUS: hrdata <= status_word;
               `WLB_REG_DMADDR: hrdata <= {23'h000000, dm_addr_r};
               `WLB_REG_DMDATA: hrdata <= {16'h0000, dm_mem[dm_addr_r]};
               `WLB_REG_RESULT: hrdata <= {16'h0000, res_r};
               default:         hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ---- design/wlb_defs.vh ----
// Constants for the word logic and BCD step unit.
`ifndef WLB_DEFS_VH
`define WLB_DEFS_VH
// Function codes.
`define WLB_FUN_XOR      6'h24
`define WLB_FUN_XNOR     6'h25
`define WLB_FUN_INC      6'h26
`define WLB_FUN_DEC      6'h27
`define WLB_FUN_STC      6'h28
`define WLB_FUN_CLC      6'h29
// Operand source selectors.
`define WLB_SRC_CHAN     2'h0
`define WLB_SRC_DM       2'h1
`define WLB_SRC_IND      2'h2
`define WLB_SRC_CONST    2'h3
// Data memory size and top legal pointer.
`define WLB_DM_WORDS     512
`define WLB_DM_TOP       16'h01FF
// Register offsets (byte addresses).
`define WLB_REG_CTRL     12'h000
`define WLB_REG_OPA      12'h004
`define WLB_REG_OPB      12'h008
`define WLB_REG_DST      12'h00C
`define WLB_REG_STATUS   12'h010
`define WLB_REG_CHAN     12'h014
`define WLB_REG_DMADDR   12'h018
`define WLB_REG_DMDATA   12'h01C
`define WLB_REG_RESULT   12'h020
// Control register fields.
`define WLB_CTRL_GO      0
`define WLB_CTRL_COND    1
`define WLB_CTRL_FUN_LO  2
`define WLB_CTRL_FUN_HI  7
// Status register fields.
`define WLB_ST_BUSY      0
`define WLB_ST_ZERO      1
`define WLB_ST_ERR       2
`define WLB_ST_CARRY     3
`endif

// ---- design/wlb_bcd_step.v ----
// Four digit BCD add or subtract one, with validity check.
`timescale 1ns/10ps
module wlb_bcd_step (
   // Operand and direction
   input  wire [15:0] value,
   input  wire        down,
   // Result
   output reg  [15:0] result,
   output wire        valid
);
   reg       borrow;
   integer   i;
   reg [3:0] dig;

   assign valid = (value[3:0] <= 4'h9) && (value[7:4] <= 4'h9) &&
                  (value[11:8] <= 4'h9) && (value[15:12] <= 4'h9); // [RULE16]

   // Ripple the carry or borrow digit by digit; 9999+1 wraps to 0000, 0000-1 to 9999.
   always @* begin
      borrow = 1'b1;
      result = 16'h0000;
      dig    = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         dig = value[i*4 +: 4];
         if (borrow) begin
            if (down) begin
               borrow = (dig == 4'h0);
               dig    = borrow ? 4'h9 : dig - 4'h1; // [RULE10]
            end else begin
               borrow = (dig == 4'h9);
               dig    = borrow ? 4'h0 : dig + 4'h1; // [RULE9]
            end
         end
         result[i*4 +: 4] = dig;
      end
   end
endmodule

// ---- design/wlb_ptr_check.v ----
// Checks an indirect pointer word against the data memory range.
`timescale 1ns/10ps
`include "wlb_defs.vh"
module wlb_ptr_check (
   // Pointer and mode
   input  wire [15:0] ptr,
   input  wire        need_bcd,
   // Verdict and resolved word number
   output wire        ok,
   output wire [8:0]  index
);
   wire        bcd_ok;
   wire [15:0] bcd_bin;
   wire [15:0] ptr_val;

   assign bcd_ok  = (ptr[3:0] <= 4'h9) && (ptr[7:4] <= 4'h9) &&
                    (ptr[11:8] <= 4'h9) && (ptr[15:12] <= 4'h9);
   assign bcd_bin = ({12'h000, ptr[15:12]} * 16'h03E8) + ({12'h000, ptr[11:8]} * 16'h0064) +
                    ({12'h000, ptr[7:4]} * 16'h000A) + {12'h000, ptr[3:0]};
   // Pointers are normally held in BCD, so word 100 is written as 0100; need_bcd low takes them as binary.
   assign ptr_val = need_bcd ? bcd_bin : ptr;
   assign ok      = (bcd_ok || !need_bcd) && (ptr_val <= `WLB_DM_TOP); // [RULE7] [RULE8] [RULE12]
   assign index   = ptr_val[8:0];
endmodule

// ---- bench/wlb_unit_asserts.sv ----
// Concurrent checks on the ports of the word logic and BCD step unit.
`timescale 1ns/10ps
`include "wlb_defs.vh"
module wlb_unit_asserts #(
   parameter CHANNELS = 64
) (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // AHB-Lite side
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Flags
   input wire logic        zero_flag,
   input wire logic        error_flag,
   input wire logic        carry_flag
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       ctrl_ap_r;
   logic [3:0] since_ws_r;
   logic [3:0] since_cc_r;
   wire        acc = hsel & hready & htrans[1];
   wire        cmd = ctrl_ap_r & hwdata[0] & hwdata[1];
   wire  [5:0] fun = hwdata[7:2];
   wire        ws  = cmd & (fun >= `WLB_FUN_XOR) & (fun <= `WLB_FUN_DEC);
   wire        cc  = cmd & ((fun == `WLB_FUN_STC) | (fun == `WLB_FUN_CLC));
   // Counters age the last executed command so flag changes can be traced to it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ap_r  <= 1'b0;
         since_ws_r <= 4'hF;
         since_cc_r <= 4'hF;
      end else begin
         ctrl_ap_r  <= acc & hwrite & (haddr == `WLB_REG_CTRL);
         since_ws_r <= ws ? 4'h0 : (since_ws_r == 4'hF ? 4'hF : since_ws_r + 4'h1);
         since_cc_r <= cc ? 4'h0 : (since_cc_r == 4'hF ? 4'hF : since_cc_r + 4'h1);
      end
   end
   AST_READY: assert property (hreadyout) else $error("wait state inserted");
   AST_OKAY: assert property (!hresp) else $error("response not OKAY");
   AST_ZERO_CAUSE: assert property ($changed(zero_flag) |-> since_ws_r <= 4'h6)
      else $error("zero flag moved without an executed operation");
   AST_ERR_CAUSE: assert property ($changed(error_flag) |-> since_ws_r <= 4'h6)
      else $error("error flag moved without an executed operation");
   AST_CARRY_CAUSE: assert property ($changed(carry_flag) |-> since_cc_r <= 4'h6)
      else $error("carry flag moved without a carry command");
   AST_SET_CARRY: assert property (cc & (fun == `WLB_FUN_STC) |-> ##[1:6] carry_flag)
      else $error("set carry did not set the flag");
   AST_CLR_CARRY: assert property (cc & (fun == `WLB_FUN_CLC) |-> ##[1:6] !carry_flag)
      else $error("clear carry did not clear the flag");
   AST_CARRY_KEEPS: assert property (cc |=> ($stable(error_flag) && $stable(zero_flag)) [*6])
      else $error("carry command touched zero or error");
   AST_UNMAPPED: assert property (acc & !hwrite & (haddr > `WLB_REG_RESULT) |=> hrdata == 32'h0)
      else $error("unmapped read returned data");
endmodule
bind wlb_unit wlb_unit_asserts #(.CHANNELS(CHANNELS)) chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .zero_flag(zero_flag), .error_flag(error_flag),
   .carry_flag(carry_flag));

// ---- bench/wlb_seq_model.sv ----
// Program sequencer model: issues single-word AHB-Lite transfers to the unit.
`timescale 1ns/10ps
module wlb_seq_model (
   // Clock
   input wire logic        hclk,
   // Bus outputs
   output logic            hsel,
   output logic [11:0]     haddr,
   output logic [1:0]      htrans,
   output logic            hwrite,
   output logic [2:0]      hsize,
   output logic [31:0]     hwdata,
   // Bus inputs
   input wire logic        hready,
   input wire logic [31:0] hrdata
);
   initial begin
      hsel   <= 1'b0;
      haddr  <= 12'h000;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize  <= 3'h2;
      hwdata <= 32'h0;
   end
   // Each call is one bus transfer; the caller repeats a control write to re-execute.
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

// ---- bench/testbench.sv ----
// Directed tests of the word logic and BCD step unit.
`timescale 1ns/10ps
`include "wlb_defs.vh"
module testbench;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        zero_flag;
   logic        error_flag;
   logic        carry_flag;
   logic [31:0] v;
   int          fail_count = 0;
   int          checks_done = 0;
   wlb_unit #(.CHANNELS(64)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .zero_flag(zero_flag),
      .error_flag(error_flag), .carry_flag(carry_flag));
   wlb_seq_model m_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      m_u.xfer(a, 1'b1, d, v);
   endtask
   task automatic dmw(input logic [15:0] a, input logic [15:0] d);
      wr(`WLB_REG_DMADDR, {16'h0, a});
      wr(`WLB_REG_DMDATA, {16'h0, d});
   endtask
   task automatic dmr(input logic [15:0] a);
      wr(`WLB_REG_DMADDR, {16'h0, a});
      m_u.xfer(`WLB_REG_DMDATA, 1'b0, 32'h0, v);
      v = {16'h0, v[15:0]};
   endtask
   // Busy rises at the edge that takes the command word; one more edge passes before polling.
   task automatic run(input logic [5:0] f, input logic c);
      wr(`WLB_REG_CTRL, {24'h0, f, c, 1'b1});
      @(posedge hclk);
      v = 32'h1;
      for (int i = 0; i < 20 && v[0] !== 1'b0; i++) m_u.xfer(`WLB_REG_STATUS, 1'b0, 32'h0, v);
   endtask
   initial begin
      hresetn = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk("flags", 32'h0, {29'h0, zero_flag, error_flag, carry_flag});
      dmw(16'h1, 16'h0F0F);
      wr(`WLB_REG_OPA, {14'h0, 2'h3, 16'h3C3C});
      wr(`WLB_REG_OPB, {14'h0, 2'h1, 16'h0001});
      wr(`WLB_REG_DST, {14'h0, 2'h1, 16'h0002});
      run(`WLB_FUN_XOR, 1'b1);
      dmr(16'h2); chk("xor", 32'h3333, v);
      run(`WLB_FUN_XNOR, 1'b1);
      dmr(16'h2); chk("xnor", 32'hCCCC, v);
      wr(`WLB_REG_OPA, {14'h0, 2'h3, 16'h0F0F});
      run(`WLB_FUN_XOR, 1'b1);
      dmr(16'h2); chk("xor zero", 32'h0, v);
      chk("zero", 32'h1, {31'h0, zero_flag});
      wr(`WLB_REG_OPA, {14'h0, 2'h3, 16'hFFFF});
      run(`WLB_FUN_XOR, 1'b0);
      dmr(16'h2); chk("held", 32'h0, v);
      chk("zero held", 32'h1, {31'h0, zero_flag});
      run(`WLB_FUN_XNOR, 1'b1);
      dmr(16'h2); chk("xnor", 32'h0F0F, v);
      chk("zero", 32'h0, {31'h0, zero_flag});
      dmw(16'h3, 16'h1299);
      wr(`WLB_REG_DST, {14'h0, 2'h1, 16'h0003});
      run(`WLB_FUN_INC, 1'b1);
      run(`WLB_FUN_INC, 1'b1);
      dmr(16'h3); chk("inc twice", 32'h1301, v);
      run(`WLB_FUN_DEC, 1'b1);
      dmr(16'h3); chk("dec", 32'h1300, v);
      dmw(16'h3, 16'h0000);
      run(`WLB_FUN_DEC, 1'b1);
      dmr(16'h3); chk("dec wrap", 32'h9999, v);
      run(`WLB_FUN_INC, 1'b1);
      dmr(16'h3); chk("inc wrap", 32'h0, v);
      chk("zero", 32'h1, {31'h0, zero_flag});
      dmw(16'h3, 16'h12A4);
      run(`WLB_FUN_INC, 1'b1);
      dmr(16'h3); chk("bad bcd", 32'h12A4, v);
      chk("error", 32'h1, {31'h0, error_flag});
      run(`WLB_FUN_STC, 1'b1);
      run(`WLB_FUN_CLC, 1'b0);
      chk("carry", 32'h3, {30'h0, error_flag, carry_flag});
      run(`WLB_FUN_CLC, 1'b1);
      chk("carry", 32'h0, {31'h0, carry_flag});
      dmw(16'd10, 16'h0100);
      dmw(16'd100, 16'h5678);
      wr(`WLB_REG_DST, {14'h0, 2'h2, 16'd10});
      run(`WLB_FUN_INC, 1'b1);
      dmr(16'd100); chk("indirect", 32'h5679, v);
      chk("error", 32'h0, {31'h0, error_flag});
      dmw(16'd20, 16'h0600);
      wr(`WLB_REG_OPB, {14'h0, 2'h2, 16'd20});
      run(`WLB_FUN_XOR, 1'b1);
      chk("ptr range", 32'h1, {31'h0, error_flag});
      dmr(16'd100); chk("skipped", 32'h5679, v);
      dmw(16'd20, 16'h0511);
      dmw(16'd511, 16'h1111);
      dmw(16'd10, 16'h0511);
      run(`WLB_FUN_XOR, 1'b1);
      dmr(16'd511); chk("top word", 32'hEEEE, v);
      dmw(16'd10, 16'h0512);
      run(`WLB_FUN_DEC, 1'b1);
      chk("ptr step", 32'h1, {31'h0, error_flag});
      m_u.xfer(12'h040, 1'b0, 32'h0, v);
      chk("unmapped", 32'h0, v);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      finish_test();
   end
endmodule
